/* common/hbpd_defines.svh */
/*
 * constants of the half-bridge input decoder: register offsets, field
 * positions, reset values, scheme and strap codes, pipeline latency.
 * assumes inclusion by bare name from package and design files.
 */
`ifndef HBPD_DEFINES_SVH
`define HBPD_DEFINES_SVH

// ****************************************************************
// scheme codes
// ****************************************************************
`define HBPD_SCHEME_SIX     2'h0
`define HBPD_SCHEME_THREE   2'h1
`define HBPD_SCHEME_SINGLE  2'h2
`define HBPD_SCHEME_INDEP   2'h3

// ****************************************************************
// strap levels as resolved by the pin sense stage
// ****************************************************************
`define HBPD_STRAP_GND      2'h0
`define HBPD_STRAP_RES47K   2'h1
`define HBPD_STRAP_OPEN     2'h2
`define HBPD_STRAP_HIGH     2'h3

// ****************************************************************
// register map
// ****************************************************************
`define HBPD_CTRL_OFS       8'h00
`define HBPD_STAT_OFS       8'h04
`define HBPD_CTRL_RESET     32'h00000000

// control fields
`define HBPD_CTRL_SCHEME_LSB 0
`define HBPD_CTRL_FW_BIT     2
`define HBPD_CTRL_STRAP_BIT  3

// status fields
`define HBPD_STAT_SCHEME_LSB 0
`define HBPD_STAT_HIGH_LSB   2
`define HBPD_STAT_LOW_LSB    5
`define HBPD_STAT_PIN_LSB    8
`define HBPD_STAT_STRAP_LSB  14

// ****************************************************************
// timing
// ****************************************************************
`define HBPD_GATE_LATENCY    3

`endif

/* common/hbpd_pkg.sv */
/*
 * types shared by the decoder top, the leg module and their interface.
 * assumes hbpd_defines.svh is on the include path.
 */
`include "hbpd_defines.svh"

package hbpd_pkg;

	// role that the commutation table gives one half-bridge
	typedef enum logic [1:0] {
		HBPD_ROLE_OFF,
		HBPD_ROLE_MOD,
		HBPD_ROLE_LOW
	} hbpd_role_t;

endpackage

/* common/hbpd_leg_if.sv */
/*
 * carrier between the decoder top and one half-bridge leg decoder.
 * assumes hbpd_pkg compiled first.
 */
`timescale 1ns/1ps

interface hbpd_leg_if;
	import hbpd_pkg::*;

	logic [1:0] scheme;
	logic       high_in;
	logic       low_in;
	logic       pwm;
	logic       freewheel;
	logic       brake;
	hbpd_role_t role;
	logic       high_gate;
	logic       low_gate;

	modport ctl (
		output scheme,
		output high_in,
		output low_in,
		output pwm,
		output freewheel,
		output brake,
		output role,
		input  high_gate,
		input  low_gate
	);

	modport leg (
		input  scheme,
		input  high_in,
		input  low_in,
		input  pwm,
		input  freewheel,
		input  brake,
		input  role,
		output high_gate,
		output low_gate
	);
endinterface

/* src/hbpd_phase_leg.sv */
/*
 * combinational gate decode of one half-bridge for all four schemes.
 * assumes synchronised inputs and a role from the commutation table.
 */
`timescale 1ns/1ps
`include "hbpd_defines.svh"

module hbpd_phase_leg
	import hbpd_pkg::*;
(
	hbpd_leg_if.leg bus
);

	// ****************************************************************
	// per-scheme decode
	// ****************************************************************
	// both inputs high floats the leg, never both gates
	wire six_high   = bus.high_in & ~bus.low_in;
	wire six_low    = bus.low_in & ~bus.high_in;
	// low input gates the leg, high input steers complementarily
	wire three_high = bus.low_in & bus.high_in;
	wire three_low  = bus.low_in & ~bus.high_in;

	// modulated leg: low gate is !pwm unless freewheeling on the diode
	wire mod_low    = ~bus.freewheel & ~bus.pwm;
	wire one_high   = ~bus.brake & (bus.role == HBPD_ROLE_MOD) & bus.pwm;
	wire one_low    = bus.brake | (bus.role == HBPD_ROLE_LOW) |
		((bus.role == HBPD_ROLE_MOD) & mod_low);

	// ****************************************************************
	// scheme select
	// ****************************************************************
	wire sel_six    = bus.scheme == `HBPD_SCHEME_SIX;
	wire sel_three  = bus.scheme == `HBPD_SCHEME_THREE;
	wire sel_single = bus.scheme == `HBPD_SCHEME_SINGLE;

	// independent scheme passes the pins straight, no interlock
	assign bus.high_gate = sel_six ? six_high : sel_three ? three_high :
		sel_single ? one_high : bus.high_in;
	assign bus.low_gate  = sel_six ? six_low : sel_three ? three_low :
		sel_single ? one_low : bus.low_in;

endmodule

/* src/hbpd_decoder.sv */
/*
 * half-bridge input decoder: six control pins to six gate enables,
 * selectable scheme, single-input six-step commutation, ahb-lite
 * register slave. assumes one 40 MHz clock, pins synchronous to it,
 * a zero-wait ahb-lite master and a resolved two-bit strap level.
 */
// The implementer's own choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`include "hbpd_defines.svh"

// Function
// - scheme field 00 six-input, 01 three-input, 10 single-input commutation
// - strapped pin: ground six, 47 k three, open single-input
// - six-input: each leg follows its pair, lone input drives its gate
// - six-input: both inputs high turns both gates off
// - three-input: low input low floats the leg
// - three-input: low input high, high input drives gates complementarily
// - single-input: phase A high input is the modulation signal
// - single-input: A low, B high, B low form commutation state
// - single-input: phase C high input reverses via complemented codes
// - single-input: phase C low input low brakes, all low gates on
// - forward codes map to the six-step phase pairs
// - code 000 all off, 111 aligns A modulated, B C low on
// - synchronous rectification: modulated low gate gets inverted modulation
// - freewheel select set: modulated low gate stays off
// - scheme 11 drives each gate straight from its input
module hbpd_decoder
	import hbpd_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input  wire logic              clock,
	input  wire logic              rst,
	input  wire logic              hsel,
	input  wire logic [ADDR_W-1:0] haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic              hready,
	input  wire logic [31:0]       hwdata,
	output logic      [31:0]       hrdata,
	output logic                   hreadyout,
	output logic                   hresp,
	input  wire logic [1:0]        mode_strap,
	input  wire logic              phase_a_high_input,
	input  wire logic              phase_a_low_input,
	input  wire logic              phase_b_high_input,
	input  wire logic              phase_b_low_input,
	input  wire logic              phase_c_high_input,
	input  wire logic              phase_c_low_input,
	output logic                   phase_a_high_gate,
	output logic                   phase_a_low_gate,
	output logic                   phase_b_high_gate,
	output logic                   phase_b_low_gate,
	output logic                   phase_c_high_gate,
	output logic                   phase_c_low_gate
);

	// ****************************************************************
	// declarations
	// ****************************************************************
	logic [5:0]  sync1_r;
	logic [5:0]  sync2_r;
	logic [1:0]  scheme_r;
	logic        freewheel_r;
	logic        use_strap_r;
	logic [1:0]  strap_r;
	logic        strap_done_r;
	logic [2:0]  high_gate_r;
	logic [2:0]  low_gate_r;
	logic        wr_pend_r;
	logic [ADDR_W-1:0] wr_addr_r;
	logic [31:0] hrdata_r;
	logic        hreadyout_r;
	logic        hresp_r;
	hbpd_role_t  role_w [3];
	wire  [2:0]  leg_high_w;
	wire  [2:0]  leg_low_w;

	// ****************************************************************
	// input synchroniser
	// ****************************************************************
	// first stage is read only by the second
	wire [5:0] pin_w = {phase_c_low_input, phase_b_low_input, phase_a_low_input,
		phase_c_high_input, phase_b_high_input, phase_a_high_input};

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sync1_r <= 6'h00;
			sync2_r <= 6'h00;
		end else begin
			sync1_r <= pin_w;
			sync2_r <= sync1_r;
		end
	end

	wire [2:0] high_in_w = sync2_r[2:0];
	wire [2:0] low_in_w  = sync2_r[5:3];

	// ****************************************************************
	// strap capture
	// ****************************************************************
	// caught once after release so a floating strap cannot wobble the scheme
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			strap_r      <= `HBPD_STRAP_GND;
			strap_done_r <= 1'b0;
		end else if (!strap_done_r) begin
			strap_r      <= mode_strap;
			strap_done_r <= 1'b1;
		end
	end

	// strap levels map one to one onto scheme codes
	wire [1:0] strap_scheme_w = (strap_r == `HBPD_STRAP_GND)    ? `HBPD_SCHEME_SIX :
		(strap_r == `HBPD_STRAP_RES47K) ? `HBPD_SCHEME_THREE :
		(strap_r == `HBPD_STRAP_OPEN)   ? `HBPD_SCHEME_SINGLE :
		`HBPD_SCHEME_INDEP;
	// no guard against live changes; the controller idles the pins first
	wire [1:0] active_w = use_strap_r ? strap_scheme_w : scheme_r;

	// ****************************************************************
	// single-input commutation
	// ****************************************************************
	wire [2:0] code_raw_w  = {low_in_w[0], high_in_w[1], low_in_w[1]};
	// stop and align keep their codes in reverse
	wire       code_fixed_w = (code_raw_w == 3'h0) || (code_raw_w == 3'h7);
	wire [2:0] code_w = (high_in_w[2] && !code_fixed_w) ? ~code_raw_w : code_raw_w;
	wire       brake_w = ~low_in_w[2];
	wire       pwm_w   = high_in_w[0];

	always_comb begin
		role_w[0] = HBPD_ROLE_OFF;
		role_w[1] = HBPD_ROLE_OFF;
		role_w[2] = HBPD_ROLE_OFF;
		case (code_w)
			3'h7: begin
				role_w[0] = HBPD_ROLE_MOD;
				role_w[1] = HBPD_ROLE_LOW;
				role_w[2] = HBPD_ROLE_LOW;
			end
			3'h6: begin
				role_w[1] = HBPD_ROLE_MOD;
				role_w[2] = HBPD_ROLE_LOW;
			end
			3'h4: begin
				role_w[0] = HBPD_ROLE_MOD;
				role_w[2] = HBPD_ROLE_LOW;
			end
			3'h5: begin
				role_w[0] = HBPD_ROLE_MOD;
				role_w[1] = HBPD_ROLE_LOW;
			end
			3'h1: begin
				role_w[2] = HBPD_ROLE_MOD;
				role_w[1] = HBPD_ROLE_LOW;
			end
			3'h3: begin
				role_w[2] = HBPD_ROLE_MOD;
				role_w[0] = HBPD_ROLE_LOW;
			end
			3'h2: begin
				role_w[1] = HBPD_ROLE_MOD;
				role_w[0] = HBPD_ROLE_LOW;
			end
			default: begin
				role_w[0] = HBPD_ROLE_OFF;
			end
		endcase
	end

	// ****************************************************************
	// half-bridge legs
	// ****************************************************************
	for (genvar i = 0; i < 3; i++) begin : g_leg
		hbpd_leg_if leg_bus ();

		assign leg_bus.scheme    = active_w;
		assign leg_bus.high_in   = high_in_w[i];
		assign leg_bus.low_in    = low_in_w[i];
		assign leg_bus.pwm       = pwm_w;
		assign leg_bus.freewheel = freewheel_r;
		assign leg_bus.brake     = brake_w;
		assign leg_bus.role      = role_w[i];
		assign leg_high_w[i]     = leg_bus.high_gate;
		assign leg_low_w[i]      = leg_bus.low_gate;

		hbpd_phase_leg u_leg (
			.bus (leg_bus.leg)
		);
	end

	// gate enables leave through flops to keep glitches off the drivers
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			high_gate_r <= 3'h0;
			low_gate_r  <= 3'h0;
		end else begin
			high_gate_r <= leg_high_w;
			low_gate_r  <= leg_low_w;
		end
	end

	assign phase_a_high_gate = high_gate_r[0];
	assign phase_b_high_gate = high_gate_r[1];
	assign phase_c_high_gate = high_gate_r[2];
	assign phase_a_low_gate  = low_gate_r[0];
	assign phase_b_low_gate  = low_gate_r[1];
	assign phase_c_low_gate  = low_gate_r[2];

	// ****************************************************************
	// ahb-lite slave
	// ****************************************************************
	// zero wait, always okay; only word writes are meaningful
	wire take_w     = hsel && hready && htrans[1];
	wire ctrl_hit_w = haddr == ADDR_W'(`HBPD_CTRL_OFS);
	wire stat_hit_w = haddr == ADDR_W'(`HBPD_STAT_OFS);
	wire ctrl_wr_w  = wr_pend_r && (wr_addr_r == ADDR_W'(`HBPD_CTRL_OFS));

	wire [31:0] ctrl_word_w = {28'h0000000, use_strap_r, freewheel_r, scheme_r};
	// forward a pending write so a read right after it sees the new value
	wire [31:0] ctrl_view_w = ctrl_wr_w ? {28'h0000000, hwdata[3:0]} : ctrl_word_w;
	wire [31:0] stat_word_w = {16'h0000, strap_r, sync2_r, low_gate_r, high_gate_r,
		active_w};
	wire [31:0] rd_val_w = ctrl_hit_w ? ctrl_view_w :
		stat_hit_w ? stat_word_w : 32'h00000000;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= '0;
		end else begin
			wr_pend_r <= take_w && hwrite;
			wr_addr_r <= haddr;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			scheme_r    <= 2'(`HBPD_CTRL_RESET >> `HBPD_CTRL_SCHEME_LSB);
			freewheel_r <= 1'b0;
			use_strap_r <= 1'b0;
		end else if (ctrl_wr_w) begin
			scheme_r    <= hwdata[`HBPD_CTRL_SCHEME_LSB +: 2];
			freewheel_r <= hwdata[`HBPD_CTRL_FW_BIT];
			use_strap_r <= hwdata[`HBPD_CTRL_STRAP_BIT];
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			hrdata_r    <= 32'h00000000;
			hreadyout_r <= 1'b1;
			hresp_r     <= 1'b0;
		end else if (take_w && !hwrite) begin
			hrdata_r    <= rd_val_w;
		end
	end

	assign hrdata    = hrdata_r;
	assign hreadyout = hreadyout_r;
	assign hresp     = hresp_r;

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	wire m_six = active_w == `HBPD_SCHEME_SIX;
	wire m_thr = active_w == `HBPD_SCHEME_THREE;
	wire m_one = active_w == `HBPD_SCHEME_SINGLE;
	wire m_ind = active_w == `HBPD_SCHEME_INDEP;

	sel_ctrl_a: assert property (ctrl_wr_w && !hwdata[`HBPD_CTRL_STRAP_BIT] |=>
		active_w == $past(hwdata[`HBPD_CTRL_SCHEME_LSB +: 2]))
		else $error("scheme not taken from control field");
	sel_strap_a: assert property (use_strap_r && strap_r == `HBPD_STRAP_RES47K
		|-> m_thr)
		else $error("resistor strap did not select three-input");
	six_map_a: assert property (m_six |=> high_gate_r == $past(high_in_w & ~low_in_w)
		&& low_gate_r == $past(low_in_w & ~high_in_w))
		else $error("six-input gate map wrong");
	six_shoot_a: assert property (m_six |=>
		((high_gate_r | low_gate_r) & $past(high_in_w & low_in_w)) == 3'h0)
		else $error("six-input both high did not float");
	three_float_a: assert property (m_thr |=>
		((high_gate_r | low_gate_r) & ~$past(low_in_w)) == 3'h0)
		else $error("three-input float failed");
	three_comp_a: assert property (m_thr |=>
		high_gate_r == $past(low_in_w & high_in_w) &&
		(high_gate_r ^ low_gate_r) == $past(low_in_w))
		else $error("three-input not complementary");
	brake_all_a: assert property (m_one && brake_w |=>
		high_gate_r == 3'h0 && low_gate_r == 3'h7)
		else $error("brake did not force low gates");
	stop_off_a: assert property (m_one && !brake_w && code_raw_w == 3'h0 |=>
		high_gate_r == 3'h0 && low_gate_r == 3'h0)
		else $error("stop state left a gate on");
	align_state_a: assert property (m_one && !brake_w && code_raw_w == 3'h7 |=>
		high_gate_r == {2'h0, $past(pwm_w)} &&
		low_gate_r[2:1] == 2'h3)
		else $error("align state wrong");
	fwd_ac_a: assert property (m_one && !brake_w && !high_in_w[2] &&
		!freewheel_r && code_raw_w == 3'h4 |=>
		high_gate_r == {2'h0, $past(pwm_w)} &&
		low_gate_r == {1'b1, 1'b0, ~$past(pwm_w)})
		else $error("state a to c wrong");
	rev_ac_a: assert property (m_one && !brake_w && high_in_w[2] &&
		code_raw_w == 3'h3 |=> high_gate_r[1] == 1'b0 && low_gate_r[2] == 1'b1
		&& high_gate_r[0] == $past(pwm_w))
		else $error("reverse code not recognised");
	async_off_a: assert property (m_one && freewheel_r && !brake_w |=>
		(low_gate_r & high_gate_r) == 3'h0 && (low_gate_r[0] == 1'b0 ||
		$past(role_w[0]) != HBPD_ROLE_MOD))
		else $error("freewheel left modulated low gate on");
	indep_pass_a: assert property (m_ind |=> high_gate_r == $past(high_in_w) &&
		low_gate_r == $past(low_in_w))
		else $error("independent scheme not direct");
	pin_latency_a: assert property (m_ind [*3] |=>
		high_gate_r == $past({phase_c_high_input, phase_b_high_input,
		phase_a_high_input}, 3))
		else $error("gate latency not three cycles");

	six_used_c: cover property (m_six && high_in_w[0] && low_in_w[0]);
	three_used_c: cover property (m_thr && low_in_w == 3'h7);
	brake_used_c: cover property (m_one && brake_w);
	rev_used_c: cover property (m_one && high_in_w[2] && code_raw_w == 3'h1);

endmodule

/* test/hbpd_pin_model.sv */
/*
 * controller side of the decoder: drives the six control pins.
 * assumes requests change right after a rising clock edge.
 */
`timescale 1ns/1ps

// ****************************************************************
// pin model
// ****************************************************************
module hbpd_pin_model (
	input  wire logic       quiet,
	input  wire logic       low_hold,
	input  wire logic [5:0] req,
	output logic            phase_a_high_input,
	output logic            phase_a_low_input,
	output logic            phase_b_high_input,
	output logic            phase_b_low_input,
	output logic            phase_c_high_input,
	output logic            phase_c_low_input
);
	logic [5:0] drive;

	// low inputs parked high when the float state is never wanted
	assign drive = low_hold ? (req | 6'h15) : req;
	// all pins low around any scheme change, state bits passed as given
	assign {phase_a_high_input, phase_a_low_input, phase_b_high_input,
		phase_b_low_input, phase_c_high_input,
		phase_c_low_input} = quiet ? 6'h00 : drive;
endmodule

/* test/tb_top.sv */
/*
 * self-checking bench of the half-bridge input decoder.
 * assumes the design package and defines are compiled first.
 */
`timescale 1ns/1ps
`include "hbpd_defines.svh"

module tb_top;
	logic        clock, rst, hsel, hwrite, hreadyout, hresp;
	logic        quiet, low_hold, gate_chk, rd_chk;
	logic [7:0]  haddr;
	logic [1:0]  htrans, mode_strap;
	logic [2:0]  hsize;
	logic [31:0] hwdata, hrdata, seed;
	logic [5:0]  req;
	wire  [5:0]  pins, gates;
	logic [5:0]  gate_q[$];
	logic [31:0] word_q[$];
	logic [3:0]  cfgs[7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h6, 4'h8, 4'hc};
	int          n_errors, num_checks, cyc;

	hbpd_pin_model ctl (.quiet(quiet), .low_hold(low_hold), .req(req),
		.phase_a_high_input(pins[5]), .phase_a_low_input(pins[4]),
		.phase_b_high_input(pins[3]), .phase_b_low_input(pins[2]),
		.phase_c_high_input(pins[1]), .phase_c_low_input(pins[0]));

	hbpd_decoder dut (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
		.hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.mode_strap(mode_strap),
		.phase_a_high_input(pins[5]), .phase_a_low_input(pins[4]),
		.phase_b_high_input(pins[3]), .phase_b_low_input(pins[2]),
		.phase_c_high_input(pins[1]), .phase_c_low_input(pins[0]),
		.phase_a_high_gate(gates[5]), .phase_a_low_gate(gates[4]),
		.phase_b_high_gate(gates[3]), .phase_b_low_gate(gates[2]),
		.phase_c_high_gate(gates[1]), .phase_c_low_gate(gates[0]));

	// ****************************************************************
	// reference and helpers
	// ****************************************************************
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction

	// vectors ordered {ah, al, bh, bl, ch, cl} on both sides
	function automatic logic [5:0] ref_gates(input logic [1:0] sc, input logic fw,
		input logic [5:0] p);
		logic [5:0] g;
		logic [2:0] cd, m, lo;
		logic       h, l;
		g = 6'h00;
		if (sc != 2'h2) begin
			for (int i = 0; i < 3; i++) begin
				h = p[5-2*i];
				l = p[4-2*i];
				case (sc)
					2'h0: g[5-2*i -: 2] = {h & ~l, l & ~h};
					2'h1: g[5-2*i -: 2] = {h & l, l & ~h};
					default: g[5-2*i -: 2] = {h, l};
				endcase
			end
			return g;
		end
		if (!p[0])
			return 6'h15;
		cd = {p[4], p[3], p[2]};
		// stop and align read the same in reverse
		if (p[1] && cd != 3'h0 && cd != 3'h7)
			cd = ~cd;
		case (cd)
			3'h6: {m, lo} = 6'h11;
			3'h4: {m, lo} = 6'h21;
			3'h5: {m, lo} = 6'h22;
			3'h1: {m, lo} = 6'h0a;
			3'h3: {m, lo} = 6'h0c;
			3'h2: {m, lo} = 6'h14;
			3'h7: {m, lo} = 6'h23;
			default: {m, lo} = 6'h00;
		endcase
		for (int j = 0; j < 3; j++) begin
			g[2*j+1] = m[j] & p[5];
			g[2*j] = lo[j] | (m[j] & ~fw & ~p[5]);
		end
		return g;
	endfunction

	task automatic cmp_gate(input logic [5:0] e, input logic [5:0] s);
		num_checks++;
		if (s !== e) begin
			n_errors++;
			$display("Error gates expected %b seen %b", e, s);
		end
	endtask

	task automatic cmp_word(input string n, input logic [31:0] e, input logic [31:0] s);
		num_checks++;
		if (s !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ****************************************************************
	// drivers
	// ****************************************************************
	// the wait has no count of its own: the cycle ceiling cuts a hang
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] e);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= a;
		do @(posedge clock); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wr ? d : 32'h0;
		if (!wr) begin
			word_q.push_back(e);
			rd_chk <= 1'b1;
		end
		do @(posedge clock); while (hreadyout !== 1'b1);
		rd_chk <= 1'b0;
	endtask

	// pins held four edges so the fixed path latency has landed
	task automatic vec(input logic [1:0] sc, input logic fw, input logic [5:0] p,
		input logic f);
		low_hold <= f;
		req <= p;
		repeat (3) @(posedge clock);
		gate_q.push_back(ref_gates(sc, fw, f ? (p | 6'h15) : p));
		gate_chk <= 1'b1;
		@(posedge clock);
		gate_chk <= 1'b0;
	endtask

	task automatic run_cfg(input logic [3:0] c, input logic [1:0] s);
		logic [1:0] sc;
		logic [5:0] g;
		sc = c[3] ? s : c[1:0];
		quiet <= 1'b1;
		@(posedge clock);
		bus(1'b1, `HBPD_CTRL_OFS, {28'h0, c}, 32'h0);
		bus(1'b0, `HBPD_CTRL_OFS, 32'h0, {28'h0, c});
		quiet <= 1'b0;
		for (int i = 0; i < 64; i++)
			vec(sc, c[2], i[5:0], 1'b0);
		for (int i = 0; i < 16; i++) begin
			seed = xs(seed);
			vec(sc, c[2], seed[5:0], sc == 2'h1);
		end
		low_hold <= 1'b0;
		quiet <= 1'b1;
		repeat (4) @(posedge clock);
		g = ref_gates(sc, c[2], 6'h00);
		bus(1'b1, `HBPD_STAT_OFS, 32'hffffffff, 32'h0);
		bus(1'b0, `HBPD_STAT_OFS, 32'h0,
			{16'h0, s, 6'h00, g[0], g[2], g[4], g[1], g[3], g[5], sc});
	endtask

	task automatic do_reset(input logic [1:0] s);
		rst <= 1'b1;
		mode_strap <= s;
		quiet <= 1'b1;
		req <= 6'h00;
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
	endtask

	// ****************************************************************
	// monitor, clock, ceiling, main sequence
	// ****************************************************************
	always @(posedge clock) begin
		if (gate_chk)
			cmp_gate(gate_q.pop_front(), gates);
		if (rd_chk && hreadyout === 1'b1) begin
			cmp_word("hrdata", word_q.pop_front(), hrdata);
			cmp_word("hresp", 32'h0, {31'h0, hresp});
		end
	end

	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	// longest run is near 10000 cycles
	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			$display("Error cycles expected below 20000 seen %0d", cyc);
			end_sim();
		end
	end

	initial begin
		hsel = 1'b0;
		hwrite = 1'b0;
		haddr = 8'h00;
		htrans = 2'h0;
		hsize = 3'h2;
		hwdata = 32'h0;
		low_hold = 1'b0;
		gate_chk = 1'b0;
		rd_chk = 1'b0;
		seed = 32'h6b2561dd;
		for (int s = 0; s < 4; s++) begin
			do_reset(s[1:0]);
			bus(1'b0, `HBPD_CTRL_OFS, 32'h0, `HBPD_CTRL_RESET);
			seed = xs(seed);
			bus(1'b1, 8'h08, seed, 32'h0);
			bus(1'b0, 8'h08, 32'h0, 32'h0);
			foreach (cfgs[k])
				run_cfg(cfgs[k], s[1:0]);
			$display("strap %0d done, mismatches %0d", s, n_errors);
		end
		end_sim();
	end
endmodule
